// File: verilog/tcm_pkg.sv
/*
  tcm_pkg: constants and types for the 16-bit three-mode timer/counter.
  assumes an APB slave with 32-bit data and one clock core_clk_i.
*/
// Notes on behaviour
// - three modes: timer, event, window
// - raw oscillator source times warm-up
// - timer counts tick, match irq, clears
// - slow-two fast clock timer compares upper five
// - event mode counts pin rising edges
// - event match checked on pin falling edge
// - window counts tick while pin high
// - window match raises irq, clears counter
// - compare commits only on high write
// - run clear stops, clears; stop mode clears run
package tcm_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMP_LO = 12'h004;
  localparam logic [11:0] ADDR_CMP_HI = 12'h008;
  localparam logic [11:0] ADDR_COUNT = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_POWER = 12'h014;
  localparam logic [15:0] CMP_RESET = 16'hFFFF;
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_EVENT = 3'h4;
  localparam logic [2:0] MODE_WINDOW = 3'h5;
  localparam logic [2:0] CLK_FC = 3'h4;
  localparam logic [2:0] CLK_FS = 3'h5;
  localparam logic [2:0] CLK_EXT = 3'h7;
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_SLOW_MODE_TWO = 2'h2;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CLK_LSB = 3;
  localparam int CTRL_RUN_BIT = 6;
  localparam int DIV_W = 24;
  typedef struct packed {
    logic run_control;
    logic [2:0] source_clock_select;
    logic [2:0] mode;
  } tcm_ctrl_t;
  localparam tcm_ctrl_t CTRL_RESET = '{run_control: 1'b0, source_clock_select: 3'h0, mode: 3'h0};
endpackage

// File: verilog/tcm_tick_gen.sv
/*
  tcm_tick_gen: free-running divider giving one-cycle ticks for the sources.
  assumes core_clk_i stands for the high-frequency clock; low-frequency clock arrives as a pin.
*/
`timescale 1ns/1ns
module tcm_tick_gen
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] source_clock_select_i,
  input wire logic divider_source_select_i,
  input wire logic low_freq_clock_i,
  output logic tick_o
);
  logic [tcm_pkg::DIV_W-1:0] div;
  logic [tcm_pkg::DIV_W-1:0] next_div;
  logic [15:0] sdiv;
  logic [15:0] next_sdiv;
  logic [2:0] fs_sync;
  logic [2:0] next_fs_sync;
  logic fs_rise;
  logic next_tick;
  logic [tcm_pkg::DIV_W-1:0] div_nxt;
  logic [15:0] sdiv_nxt;
  always_comb
  begin
    next_fs_sync = {fs_sync[1:0], low_freq_clock_i};
    fs_rise = fs_sync[1] & ~fs_sync[2];
    next_div = div + 24'h000001;
    next_sdiv = fs_rise ? sdiv + 16'h0001 : sdiv;
    div_nxt = next_div;
    sdiv_nxt = next_sdiv;
    // each tap ticks when the bits below it wrap to zero, so on every toggle of its bit
    unique case (source_clock_select_i)
      3'h0: next_tick = divider_source_select_i ? (fs_rise & sdiv_nxt[14:0] == 15'h0000)
                                               : (div_nxt[22:0] == 23'h000000);
      3'h1: next_tick = divider_source_select_i ? (fs_rise & sdiv_nxt[4:0] == 5'h00)
                                               : (div_nxt[12:0] == 13'h0000);
      3'h2: next_tick = div_nxt[7:0] == 8'h00;
      3'h3: next_tick = div_nxt[2:0] == 3'h0;
      3'h4: next_tick = 1'b1;
      3'h5: next_tick = fs_rise;
      default: next_tick = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div <= 24'h000000;
      sdiv <= 16'h0000;
      fs_sync <= 3'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      div <= next_div;
      sdiv <= next_sdiv;
      fs_sync <= next_fs_sync;
      tick_o <= next_tick;
    end
  end
endmodule

// File: verilog/tcm_timer.sv
/*
  tcm_timer: 16-bit up counter with timer, event and window modes, APB registers.
  assumes count_input_pin and low_freq_clock are asynchronous pins; stop_mode_i from power logic.
*/
`timescale 1ns/1ns
module tcm_timer
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_input_pin_i,
  input wire logic low_freq_clock_i,
  input wire logic stop_mode_i,
  output logic match_interrupt_o
);
  tcm_pkg::tcm_ctrl_t ctrl;
  tcm_pkg::tcm_ctrl_t next_ctrl;
  logic [15:0] compare_value_reg;
  logic [15:0] next_compare_value_reg;
  logic [7:0] compare_low_byte;
  logic [7:0] next_compare_low_byte;
  logic low_pending;
  logic next_low_pending;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [1:0] power_mode;
  logic [1:0] next_power_mode;
  logic divider_source_select;
  logic next_divider_source_select;
  logic [2:0] pin_sync;
  logic [2:0] next_pin_sync;
  logic event_armed;
  logic next_event_armed;
  logic next_match;
  logic [31:0] next_prdata;
  logic tick;
  logic wr;
  logic rd;
  logic pin_hi;
  logic pin_rise;
  logic pin_fall;
  logic hit;

  assign pready = 1'b1;

  function automatic logic cmp_hit(input logic [15:0] c, input logic [15:0] r, input logic upper_only);
    cmp_hit = upper_only ? (c[15:11] == r[15:11]) : (c == r);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == tcm_pkg::ADDR_CTRL) || (a == tcm_pkg::ADDR_CMP_LO) || (a == tcm_pkg::ADDR_CMP_HI)
      || (a == tcm_pkg::ADDR_COUNT) || (a == tcm_pkg::ADDR_STATUS) || (a == tcm_pkg::ADDR_POWER);
  endfunction

  assign pslverr = psel & penable & ~mapped(paddr);

  tcm_tick_gen u_tick
  (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .source_clock_select_i(ctrl.source_clock_select),
    .divider_source_select_i(divider_source_select),
    .low_freq_clock_i(low_freq_clock_i),
    .tick_o(tick)
  );

  always_comb
  begin
    wr = psel & penable & pwrite & mapped(paddr);
    rd = psel & ~penable & ~pwrite;
    next_pin_sync = {pin_sync[1:0], count_input_pin_i};
    pin_hi = pin_sync[1];
    pin_rise = pin_sync[1] & ~pin_sync[2];
    pin_fall = ~pin_sync[1] & pin_sync[2];
    next_ctrl = ctrl;
    next_compare_value_reg = compare_value_reg;
    next_compare_low_byte = compare_low_byte;
    next_low_pending = low_pending;
    next_power_mode = power_mode;
    next_divider_source_select = divider_source_select;
    next_count = count;
    next_event_armed = event_armed;
    next_match = 1'b0;
    next_prdata = prdata;
    hit = 1'b0;
    if (wr)
    begin
      unique case (paddr)
        tcm_pkg::ADDR_CTRL:
        begin
          next_ctrl = tcm_pkg::tcm_ctrl_t'(pwdata[6:0]);
        end
        tcm_pkg::ADDR_CMP_LO:
        begin
          next_compare_low_byte = pwdata[7:0];
          next_low_pending = 1'b1;
        end
        tcm_pkg::ADDR_CMP_HI:
        begin
          if (low_pending)
          begin
            next_compare_value_reg = {pwdata[7:0], compare_low_byte};
          end
          next_low_pending = 1'b0;
        end
        tcm_pkg::ADDR_POWER:
        begin
          next_power_mode = pwdata[1:0];
          next_divider_source_select = pwdata[2];
        end
        default:
        begin
          next_low_pending = low_pending;
        end
      endcase
    end
    if (!ctrl.run_control)
    begin
      next_count = 16'h0000;
      next_event_armed = 1'b0;
    end
    else
    begin
      unique case (ctrl.mode)
        tcm_pkg::MODE_EVENT:
        begin
          if (pin_rise)
          begin
            next_count = count + 16'h0001;
            next_event_armed = 1'b1;
          end
          else if (pin_fall && event_armed)
          begin
            next_event_armed = 1'b0;
            if (cmp_hit(count, compare_value_reg, 1'b0))
            begin
              hit = 1'b1;
            end
          end
        end
        tcm_pkg::MODE_WINDOW:
        begin
          if (tick && pin_hi)
          begin
            next_count = count + 16'h0001;
            hit = cmp_hit(next_count, compare_value_reg, 1'b0);
          end
        end
        default:
        begin
          if (tick)
          begin
            next_count = count + 16'h0001;
            hit = cmp_hit(next_count, compare_value_reg,
              power_mode == tcm_pkg::PWR_SLOW_MODE_TWO && ctrl.source_clock_select == tcm_pkg::CLK_FC);
          end
        end
      endcase
      if (hit)
      begin
        next_count = 16'h0000;
        next_match = 1'b1;
      end
    end
    if (stop_mode_i)
    begin
      next_ctrl.run_control = 1'b0;
    end
    if (rd)
    begin
      unique case (paddr)
        tcm_pkg::ADDR_CTRL: next_prdata = {25'h0000000, ctrl};
        tcm_pkg::ADDR_CMP_LO: next_prdata = {24'h000000, compare_value_reg[7:0]};
        tcm_pkg::ADDR_CMP_HI: next_prdata = {24'h000000, compare_value_reg[15:8]};
        tcm_pkg::ADDR_COUNT: next_prdata = {16'h0000, count};
        tcm_pkg::ADDR_STATUS: next_prdata = {29'h00000000, pin_hi, event_armed, low_pending};
        tcm_pkg::ADDR_POWER: next_prdata = {29'h00000000, divider_source_select, power_mode};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl <= tcm_pkg::CTRL_RESET;
      compare_value_reg <= tcm_pkg::CMP_RESET;
      compare_low_byte <= 8'h00;
      low_pending <= 1'b0;
      power_mode <= tcm_pkg::PWR_NORMAL;
      divider_source_select <= 1'b0;
      count <= 16'h0000;
      pin_sync <= 3'h0;
      event_armed <= 1'b0;
      match_interrupt_o <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      ctrl <= next_ctrl;
      compare_value_reg <= next_compare_value_reg;
      compare_low_byte <= next_compare_low_byte;
      low_pending <= next_low_pending;
      power_mode <= next_power_mode;
      divider_source_select <= next_divider_source_select;
      count <= next_count;
      pin_sync <= next_pin_sync;
      event_armed <= next_event_armed;
      match_interrupt_o <= next_match;
      prdata <= next_prdata;
    end
  end
endmodule

// File: dv/tcm_properties.sv
/* checker for tcm_timer ports.
   assumes bind to tcm_timer; writes land at the access edge. */
`timescale 1ns/1ns
module tcm_properties
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic count_input_pin_i,
  input wire logic stop_mode_i,
  input wire logic match_interrupt_o
);
  logic [6:0] ctrl, next_ctrl;
  logic [15:0] cmp, next_cmp;
  logic [8:0] lo, next_lo;
  logic wr, rd, ev, win;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign ev = ctrl[2:0] == tcm_pkg::MODE_EVENT;
  assign win = ctrl[2:0] == tcm_pkg::MODE_WINDOW;
  always_comb
  begin
    next_ctrl = ctrl;
    next_cmp = cmp;
    next_lo = lo;
    if (wr && paddr == tcm_pkg::ADDR_CTRL)
    begin
      next_ctrl = pwdata[6:0];
    end
    if (wr && paddr == tcm_pkg::ADDR_CMP_LO)
    begin
      next_lo = {1'b1, pwdata[7:0]};
    end
    if (wr && paddr == tcm_pkg::ADDR_CMP_HI && lo[8])
    begin
      next_cmp = {pwdata[7:0], lo[7:0]};
      next_lo = 9'h000;
    end
    if (stop_mode_i)
    begin
      next_ctrl[6] = 1'b0;
    end
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl <= 7'h00;
      cmp <= tcm_pkg::CMP_RESET;
      lo <= 9'h000;
    end
    else
    begin
      ctrl <= next_ctrl;
      cmp <= next_cmp;
      lo <= next_lo;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence win_idle_s; (win && !count_input_pin_i)[*8]; endsequence
  sequence ev_high_s; (ev && count_input_pin_i)[*8]; endsequence
  pulse_single_a: assert property (match_interrupt_o |=> !match_interrupt_o) else $error("long pulse");
  cmp_readback_a: assert property (rd && paddr == tcm_pkg::ADDR_CMP_HI |-> prdata[7:0] == cmp[15:8])
    else $error("compare high wrong");
  ctrl_readback_a: assert property (rd && paddr == tcm_pkg::ADDR_CTRL |-> prdata[6:0] == ctrl)
    else $error("control wrong");
  stopped_quiet_a: assert property ((!ctrl[6])[*4] |-> !match_interrupt_o) else $error("match while stopped");
  stop_mode_a: assert property (stop_mode_i[*4] |-> !match_interrupt_o) else $error("match in stop");
  event_fall_a: assert property (ev && match_interrupt_o |-> !$past(count_input_pin_i)) else $error("no fall");
  event_still_a: assert property (ev_high_s |-> !match_interrupt_o) else $error("match without fall");
  window_hold_a: assert property (win_idle_s |-> !match_interrupt_o) else $error("match with pin low");
endmodule
bind tcm_timer tcm_properties i_tcm_properties (.core_clk_i, .nrst_i, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .count_input_pin_i, .stop_mode_i, .match_interrupt_o);

// File: dv/tcm_pin_src.sv
/* pulse source on the count pin, slow clock on its pin.
   assumes tasks are called between bench clock edges. */
`timescale 1ns/1ns
module tcm_pin_src
(
  input wire logic core_clk_i,
  output logic count_input_pin_o,
  output logic low_freq_clock_o
);
  initial
  begin
    count_input_pin_o = 1'b0;
    low_freq_clock_o = 1'b0;
    forever
    begin
      repeat (16) @(posedge core_clk_i);
      low_freq_clock_o <= !low_freq_clock_o;
    end
  end
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n)
    begin
      count_input_pin_o <= 1'b1;
      repeat (hi) @(posedge core_clk_i);
      count_input_pin_o <= 1'b0;
      repeat (lo) @(posedge core_clk_i);
    end
  endtask
endmodule

// File: dv/test_tcm_timer.sv
/* bench for tcm_timer.
   assumes the pin partner and the bound checker. */
`timescale 1ns/1ns
module test_tcm_timer;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_mode_i = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pin, lfc, irq;
  logic [32:0] expq[$];
  logic [7:0] rb;
  int fails = 0, comparisons = 0, irqs = 0, seed = 96, k;
  initial forever #2 core_clk_i = !core_clk_i;
  tcm_timer i_tcm_timer (.core_clk_i, .nrst_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .count_input_pin_i(pin), .low_freq_clock_i(lfc), .stop_mode_i, .match_interrupt_o(irq));
  tcm_pin_src i_tcm_pin_src (.core_clk_i, .count_input_pin_o(pin), .low_freq_clock_o(lfc));
  task automatic give_verdict();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [32:0] x, input logic [32:0] s);
    comparisons++;
    if (s !== x)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  always @(posedge core_clk_i)
  begin
    irqs += (irq === 1'b1);
    if ((psel && penable && pready && !pwrite) === 1'b1)
    begin
      chk("read", expq.pop_front(), {pslverr, prdata});
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    int n;
    @(posedge core_clk_i);
    if (!w)
    begin
      expq.push_back(x);
    end
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n == 50)
    begin
      fails++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setcmp(input logic [15:0] v);
    apb(1'b1, tcm_pkg::ADDR_CMP_LO, {24'h0, v[7:0]}, 33'h0);
    apb(1'b1, tcm_pkg::ADDR_CMP_HI, {24'h0, v[15:8]}, 33'h0);
  endtask
  task automatic wait_irq(output int t);
    t = 0;
    do
    begin
      @(posedge core_clk_i);
      t++;
    end
    while (irq !== 1'b1 && t < 20000);
    if (irq !== 1'b1)
    begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic gap(input int x);
    int a, b;
    wait_irq(a);
    wait_irq(b);
    chk("gap", 33'(x), 33'(b));
  endtask
  task automatic pulse_chk(input int n, input int hi, input int lo, input int x);
    i_tcm_pin_src.pulses(n, hi, lo);
    chk("matches", 33'(x), 33'(irqs - k));
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, tcm_pkg::ADDR_CTRL, 32'h0, 33'h0);
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
    rb = 8'($random(seed));
    apb(1'b1, tcm_pkg::ADDR_CMP_LO, {24'h0, rb}, 33'h0);
    apb(1'b0, tcm_pkg::ADDR_CMP_LO, 32'h0, 33'h0FF);
    apb(1'b1, tcm_pkg::ADDR_CMP_HI, 32'h0, 33'h0);
    apb(1'b0, tcm_pkg::ADDR_CMP_LO, 32'h0, {25'h0, rb});
    apb(1'b1, tcm_pkg::ADDR_CMP_HI, 32'h7, 33'h0);
    apb(1'b0, tcm_pkg::ADDR_CMP_HI, 32'h0, 33'h0);
    $display("test registers done");
    setcmp(16'h0003);
    apb(1'b1, tcm_pkg::ADDR_CTRL, 32'h58, 33'h0);
    gap(24);
    stop_mode_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    stop_mode_i <= 1'b0;
    apb(1'b0, tcm_pkg::ADDR_CTRL, 32'h0, 33'h018);
    k = irqs;
    repeat (100) @(posedge core_clk_i);
    chk("stopped", 33'h0, 33'(irqs - k));
    $display("test timer done");
    apb(1'b1, tcm_pkg::ADDR_POWER, 32'h2, 33'h0);
    setcmp(16'h10FF);
    apb(1'b1, tcm_pkg::ADDR_CTRL, 32'h60, 33'h0);
    gap(4096);
    apb(1'b1, tcm_pkg::ADDR_CTRL, 32'h20, 33'h0);
    apb(1'b1, tcm_pkg::ADDR_POWER, 32'h0, 33'h0);
    $display("test warm-up done");
    setcmp(16'h0003);
    apb(1'b1, tcm_pkg::ADDR_CTRL, 32'h7C, 33'h0);
    k = irqs;
    pulse_chk(2, 10, 10, 0);
    pulse_chk(1, 10, 10, 1);
    pulse_chk(3, 10, 10, 2);
    apb(1'b1, tcm_pkg::ADDR_CTRL, 32'h3C, 33'h0);
    $display("test event done");
    setcmp(16'h0004);
    apb(1'b1, tcm_pkg::ADDR_CTRL, 32'h5D, 33'h0);
    k = irqs;
    pulse_chk(1, 20, 100, 0);
    pulse_chk(1, 20, 20, 1);
    apb(1'b1, tcm_pkg::ADDR_CTRL, 32'h1D, 33'h0);
    $display("test window done");
    give_verdict();
  end
endmodule
